// *** rtl/spd_pkg.sv ***
// Constants, target codes and address helpers for the register page decoder
package spd_pkg;

   // ==========================================================
   // Address space and widths
   // ==========================================================
   localparam int SPD_DW = 8;                         // Data byte width
   localparam int SPD_AW = 8;                         // Direct address width
   localparam logic [7:0] SPD_SPACE_LO = 8'h80;       // First register address
   localparam logic [7:0] SPD_SPACE_HI = 8'hff;       // Last register address
   localparam logic [3:0] SPD_BIT_COL_A = 4'h0;       // Bit-access column, low
   localparam logic [3:0] SPD_BIT_COL_B = 4'h8;       // Bit-access column, high

   // ==========================================================
   // Page values and page-select register
   // ==========================================================
   localparam logic [7:0] SPD_PAGE_0 = 8'h00;         // Page 0
   localparam logic [7:0] SPD_PAGE_F = 8'h0f;         // Page F
   localparam logic [7:0] SPD_PAGE_SEL_ADDR = 8'ha7;  // Page-select register
   localparam logic [7:0] SPD_PAGE_SEL_RST = 8'h00;   // Page-select reset value

   // ==========================================================
   // Addresses decoded by name
   // ==========================================================
   localparam logic [7:0] SPD_GT_HIGH_ADDR = 8'hc4;   // Compare high / family id
   localparam logic [7:0] SPD_HW_ID_ADDR = 8'hc4;     // Family id on page F
   localparam logic [7:0] SPD_IRQ_EN1_ADDR = 8'he6;   // Extended irq enable one
   localparam logic [7:0] SPD_CAP_CTRL_ADDR = 8'h9a;  // Cap-sense control, page 0
   localparam logic [7:0] SPD_P4_MODE_ADDR = 8'h9a;   // Port 4 output mode, page F

   // ==========================================================
   // Decoded targets, one-hot
   // ==========================================================
   typedef enum logic [8:0] {
      spd_tgt_none      = 9'h001,  // Reserved location
      spd_tgt_page_sel  = 9'h002,  // Page-select register itself
      spd_tgt_all_page  = 9'h004,  // Other register present on all pages
      spd_tgt_paged     = 9'h008,  // Other register of page 0 or F
      spd_tgt_gt_high   = 9'h010,  // Converter greater compare high
      spd_tgt_hw_id     = 9'h020,  // Hardware family id
      spd_tgt_irq_en1   = 9'h040,  // Extended irq enable one
      spd_tgt_cap_ctrl  = 9'h080,  // Cap-sense control
      spd_tgt_p4_mode   = 9'h100   // Port 4 output mode
   } spd_target_t;

   // True for addresses that resolve the same on every page
   function automatic logic spd_is_all_page(input logic [7:0] a);
      unique case (a)
         8'h80, 8'h82, 8'h83, 8'h8e, 8'h90, 8'ha0, 8'ha7, 8'ha8,
         8'hac, 8'hb0, 8'hb2, 8'hb3, 8'hb6, 8'hb7, 8'hb8, 8'hd1,
         8'hd8, 8'he0, 8'he6, 8'he7, 8'he8, 8'hf0: spd_is_all_page = 1'b1;
         default: spd_is_all_page = 1'b0;
      endcase
   endfunction

   // True for addresses that allow single-bit access
   function automatic logic spd_is_bit_addr(input logic [7:0] a);
      spd_is_bit_addr = (a[3:0] == SPD_BIT_COL_A) || (a[3:0] == SPD_BIT_COL_B);
   endfunction

endpackage

// *** rtl/spd_sfr_decode.sv ***
// Combinational page-dependent address decode for the register space
module spd_sfr_decode
   import spd_pkg::*;
(
   input wire logic [7:0] addr,
   input wire logic [7:0] page,
   output spd_target_t target,
   output logic all_page
);

   // ==========================================================
   // Address to target
   // ==========================================================
   // Page select first, then all-page registers, then page-resolved ones
   always_comb begin
      all_page = spd_is_all_page(addr);
      if (addr == SPD_PAGE_SEL_ADDR) begin
         target = spd_tgt_page_sel;
      end else if (addr == SPD_IRQ_EN1_ADDR) begin
         target = spd_tgt_irq_en1;
      end else if (all_page) begin
         target = spd_tgt_all_page;
      end else if (page == SPD_PAGE_0) begin
         // Page 0 resolution of shared addresses
         if (addr == SPD_GT_HIGH_ADDR) begin
            target = spd_tgt_gt_high;
         end else if (addr == SPD_CAP_CTRL_ADDR) begin
            target = spd_tgt_cap_ctrl;
         end else begin
            target = spd_tgt_paged;
         end
      end else if (page == SPD_PAGE_F) begin
         // Page F resolution of shared addresses
         if (addr == SPD_HW_ID_ADDR) begin
            target = spd_tgt_hw_id;
         end else if (addr == SPD_P4_MODE_ADDR) begin
            target = spd_tgt_p4_mode;
         end else begin
            target = spd_tgt_paged;
         end
      end else begin
         // Unknown page: only all-page registers answer
         target = spd_tgt_none;
      end
   end

endmodule

// *** rtl/spd_page_decoder.sv ***
// Register page select and address decode between core and peripherals
//
// Overview of operation
// - Writing page select sets page for later accesses
// - Reading page select returns page in use
// - Page select decoded at 0xA7 on every page
// - 0xC4: compare high on 0, id on F
// - All-page registers like 0xE6 decode page-independent
// - 0x9A: port 4 mode on F, cap-sense on 0
// - Only direct accesses 0x80 to 0xFF decoded
// - Bit access only at addresses ending 0/8
module spd_page_decoder
   import spd_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic core_rd,
   input wire logic core_wr,
   input wire logic core_direct,
   input wire logic core_bit,
   input wire logic [2:0] core_bit_idx,
   input wire logic [7:0] core_addr,
   input wire logic [7:0] core_wdata,
   input wire logic [7:0] per_rdata,
   output logic [7:0] core_rdata_q,
   output logic core_rvalid_q,
   output logic [7:0] sfr_page_q,
   output logic per_sel_q,
   output logic per_rd_q,
   output logic per_wr_q,
   output logic [7:0] per_addr_q,
   output logic [7:0] per_wdata_q,
   output logic per_bit_q,
   output logic [2:0] per_bit_idx_q,
   output logic per_all_page_q,
   output spd_target_t per_target_q,
   output logic reserved_q,
   output logic bit_refused_q
);

   // ==========================================================
   // Access qualification
   // ==========================================================
   logic acc;             // Direct access that falls in the register space
   logic is_wr;           // Write wins if both strobes are seen
   logic is_rd;           // Read without a write
   logic bit_bad;         // Bit access to a byte-only address
   logic fwd;             // Access that goes to a peripheral
   logic rd_page_hold;    // Pending read answers with the page value
   logic rd_per_hold;     // Pending read answers with peripheral data
   logic [7:0] page_hold_q; // Page value captured for a pending read
   logic rd_pend_q;       // Read waiting for its answer
   logic rd_src_page_q;   // Pending read is of the page register
   logic rd_src_per_q;    // Pending read is of a peripheral
   spd_target_t dec_target; // Decoded target for this cycle
   logic dec_all_page;    // Decoded address is an all-page register

   // Only direct accesses with the top address bit set enter the space
   assign acc = (core_rd | core_wr) & core_direct & core_addr[7];
   assign is_wr = core_wr;
   assign is_rd = core_rd & ~core_wr;
   // Byte-only locations refuse single-bit access
   assign bit_bad = core_bit & ~spd_is_bit_addr(core_addr);
   // Peripherals see every decoded target except page select and reserved
   assign fwd = acc & ~bit_bad & (dec_target != spd_tgt_none) & (dec_target != spd_tgt_page_sel);
   assign rd_page_hold = acc & is_rd & ~bit_bad & (dec_target == spd_tgt_page_sel);
   assign rd_per_hold = fwd & is_rd;

   // Page-dependent decode of the current address
   spd_sfr_decode u_decode (
      .addr(core_addr),
      .page(sfr_page_q),
      .target(dec_target),
      .all_page(dec_all_page)
   );

   // ==========================================================
   // Page-select register
   // ==========================================================
   // Loaded by a byte write at its address, whatever page is selected
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sfr_page_q <= SPD_PAGE_SEL_RST;
      end else if (acc && is_wr && !bit_bad && dec_target == spd_tgt_page_sel) begin
         sfr_page_q <= core_wdata;
      end
   end

   // ==========================================================
   // Peripheral request stage
   // ==========================================================
   // One-cycle strobes with the decoded target and the write payload
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         per_sel_q <= 1'b0;
         per_rd_q <= 1'b0;
         per_wr_q <= 1'b0;
         per_addr_q <= 8'h00;
         per_wdata_q <= 8'h00;
         per_bit_q <= 1'b0;
         per_bit_idx_q <= 3'h0;
         per_all_page_q <= 1'b0;
         per_target_q <= spd_tgt_none;
      end else begin
         per_sel_q <= fwd;
         per_rd_q <= fwd & is_rd;
         per_wr_q <= fwd & is_wr;
         if (acc) begin
            // Decode details follow every space access for visibility
            per_addr_q <= core_addr;
            per_wdata_q <= core_wdata;
            per_bit_q <= core_bit;
            per_bit_idx_q <= core_bit_idx;
            per_all_page_q <= dec_all_page;
            per_target_q <= dec_target;
         end
      end
   end

   // ==========================================================
   // Error indications
   // ==========================================================
   // Reserved location hit, or bit access refused; both one-cycle pulses
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reserved_q <= 1'b0;
         bit_refused_q <= 1'b0;
      end else begin
         reserved_q <= acc & ~bit_bad & (dec_target == spd_tgt_none);
         bit_refused_q <= acc & bit_bad;
      end
   end

   // ==========================================================
   // Read answer, two cycles after the request
   // ==========================================================
   // First stage notes the source and captures the page value
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_q <= 1'b0;
         rd_src_page_q <= 1'b0;
         rd_src_per_q <= 1'b0;
         page_hold_q <= 8'h00;
      end else begin
         rd_pend_q <= acc & is_rd;
         rd_src_page_q <= rd_page_hold;
         rd_src_per_q <= rd_per_hold;
         page_hold_q <= sfr_page_q;
      end
   end

   // Second stage drives the byte; reserved or refused reads give zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         core_rvalid_q <= 1'b0;
         core_rdata_q <= 8'h00;
      end else begin
         core_rvalid_q <= rd_pend_q;
         if (rd_src_page_q) begin
            core_rdata_q <= page_hold_q;
         end else if (rd_src_per_q) begin
            core_rdata_q <= per_rdata;
         end else begin
            core_rdata_q <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Byte access to a given address
   sequence s_byte_at(logic [7:0] a);
      acc && !core_bit && core_addr == a;
   endsequence

   a_page_write_load: assert property (s_byte_at(SPD_PAGE_SEL_ADDR) and is_wr
      |=> sfr_page_q == $past(core_wdata))
      else $error("page select did not load written byte");
   a_page_read_back: assert property (s_byte_at(SPD_PAGE_SEL_ADDR) and is_rd
      |-> ##2 core_rvalid_q && core_rdata_q == $past(sfr_page_q, 2))
      else $error("page select read returned wrong value");
   a_page_any_page: assert property (s_byte_at(SPD_PAGE_SEL_ADDR)
      |=> per_target_q == spd_tgt_page_sel && !reserved_q && !per_sel_q)
      else $error("page select not decoded on this page");
   a_gt_high_page0: assert property (s_byte_at(SPD_GT_HIGH_ADDR) and sfr_page_q == SPD_PAGE_0
      |=> per_sel_q && per_target_q == spd_tgt_gt_high)
      else $error("compare high not selected on page 0");
   a_hw_id_pagef: assert property (s_byte_at(SPD_HW_ID_ADDR) and sfr_page_q == SPD_PAGE_F
      |=> per_sel_q && per_target_q == spd_tgt_hw_id)
      else $error("family id not selected on page F");
   a_irq_all_pages: assert property (s_byte_at(SPD_IRQ_EN1_ADDR)
      |=> per_sel_q && per_all_page_q && per_target_q == spd_tgt_irq_en1)
      else $error("irq enable one decoded by page");
   // Any other all-page register is forwarded as such on every page
   a_all_page_fwd: assert property (acc && !core_bit && spd_is_all_page(core_addr)
      && core_addr != SPD_PAGE_SEL_ADDR
      |=> per_sel_q && per_all_page_q && (per_target_q == spd_tgt_all_page || per_target_q == spd_tgt_irq_en1))
      else $error("all-page register not forwarded as all-page");
   a_p4_mode_pagef: assert property (s_byte_at(SPD_P4_MODE_ADDR) and sfr_page_q == SPD_PAGE_F
      |=> per_target_q == spd_tgt_p4_mode)
      else $error("port 4 mode not selected on page F");
   a_cap_ctrl_page0: assert property (s_byte_at(SPD_CAP_CTRL_ADDR) and sfr_page_q == SPD_PAGE_0
      |=> per_target_q == spd_tgt_cap_ctrl)
      else $error("cap-sense control not selected on page 0");
   a_space_only: assert property (!acc
      |=> !per_sel_q && !reserved_q && !bit_refused_q && $stable(sfr_page_q))
      else $error("access outside register space was decoded");
   // Every read in the space gets its answer two cycles later, and only reads do
   a_read_answer_time: assert property (acc && is_rd |-> ##2 core_rvalid_q)
      else $error("read answer strobe missing");
   a_read_answer_none: assert property (!(acc && is_rd) |-> ##2 !core_rvalid_q)
      else $error("read answer strobe without a read");
   // Forwarded read hands back the byte present during the strobe
   a_read_fwd_byte: assert property (per_rd_q |=> core_rvalid_q && core_rdata_q == $past(per_rdata))
      else $error("forwarded read byte not returned");
   // A refused access may follow another one back to back
   a_bit_refuse: assert property (acc && core_bit && core_addr[2:0] != 3'h0
      |=> bit_refused_q && !per_sel_q
      ##1 (!bit_refused_q || $past(acc && core_bit && core_addr[2:0] != 3'h0)))
      else $error("bit access to byte-only address not refused");
   a_refused_no_load: assert property (acc && core_bit && core_addr[2:0] != 3'h0 |=> $stable(sfr_page_q))
      else $error("refused bit access changed the page");
   a_odd_page: assert property (acc && !core_bit && sfr_page_q != SPD_PAGE_0 && sfr_page_q != SPD_PAGE_F
      && !spd_is_all_page(core_addr) |=> reserved_q && !per_sel_q)
      else $error("unknown page did not act as reserved");
   // Reserved reads still answer, with a zero byte
   a_reserved_read: assert property (acc && is_rd && !core_bit && sfr_page_q != SPD_PAGE_0
      && sfr_page_q != SPD_PAGE_F && !spd_is_all_page(core_addr) |-> ##2 core_rvalid_q && core_rdata_q == 8'h00)
      else $error("reserved read did not return zero");

endmodule

// *** sim/spd_periph_model.sv ***
// Peripheral side model answering forwarded register reads
module spd_periph_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic per_rd_q,
   input wire logic [7:0] per_addr_q,
   output logic [7:0] per_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Read data
   // ==========================================================
   logic [7:0] noise_q; // Changes every cycle so a late sample never matches
   // Pattern shown whenever no read strobe is present
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         noise_q <= 8'ha5;
      end else begin
         noise_q <= ~noise_q + 8'h01;
      end
   end
   // Valid byte only in the strobe cycle, derived from the address
   assign per_rdata = per_rd_q ? (per_addr_q ^ 8'h5a) : noise_q;
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the register page decoder
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import spd_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic clock = 1'b0, rst_n = 1'b0; // Clock and reset
   logic core_rd = 1'b0, core_wr = 1'b0, core_direct = 1'b0, core_bit = 1'b0;
   logic [2:0] core_bit_idx = 3'h0, per_bit_idx_q;
   logic [7:0] core_addr = 8'h00, core_wdata = 8'h00, per_rdata, core_rdata_q, sfr_page_q, per_addr_q, per_wdata_q;
   logic core_rvalid_q, per_sel_q, per_rd_q, per_wr_q, per_bit_q, per_all_page_q, reserved_q, bit_refused_q;
   spd_target_t per_target_q;
   int err_total = 0, checks_done = 0, cyc = 0;
   logic s_sel, s_res, s_ref, s_rv; // Sampled answers
   logic [7:0] s_pg, s_rd;
   logic [1:0] s_rw;
   logic [8:0] s_tgt;
   // Row: request, then expected target (0 = not checked), strobes, read byte, page
   typedef struct {logic rd, wr, bt; logic [7:0] a, wd; logic [8:0] tgt; logic sel, res, rf; logic [7:0] rx, pg;} spd_row_t;
   spd_row_t rows [17] = '{
      '{1,0,0,8'ha7,8'h00,9'h002,0,0,0,8'h00,8'h00}, '{1,0,0,8'hc4,8'h00,9'h010,1,0,0,8'h9e,8'h00},
      '{1,0,0,8'h9a,8'h00,9'h080,1,0,0,8'hc0,8'h00}, '{1,0,0,8'he6,8'h00,9'h040,1,0,0,8'hbc,8'h00},
      '{0,1,0,8'ha7,8'h0f,9'h002,0,0,0,8'h00,8'h0f}, '{1,0,0,8'hc4,8'h00,9'h020,1,0,0,8'h9e,8'h0f},
      '{1,0,0,8'h9a,8'h00,9'h100,1,0,0,8'hc0,8'h0f}, '{1,0,0,8'he6,8'h00,9'h040,1,0,0,8'hbc,8'h0f},
      '{1,0,0,8'ha7,8'h00,9'h002,0,0,0,8'h0f,8'h0f}, '{1,0,0,8'h81,8'h00,9'h008,1,0,0,8'hdb,8'h0f},
      '{1,0,1,8'h88,8'h00,9'h008,1,0,0,8'hd2,8'h0f}, '{1,0,1,8'h89,8'h00,9'h000,0,0,1,8'h00,8'h0f},
      '{0,1,1,8'ha7,8'h33,9'h000,0,0,1,8'h00,8'h0f}, '{0,1,0,8'ha7,8'h33,9'h002,0,0,0,8'h00,8'h33},
      '{1,0,0,8'h9a,8'h00,9'h001,0,1,0,8'h00,8'h33}, '{1,0,0,8'he6,8'h00,9'h040,1,0,0,8'hbc,8'h33},
      '{1,0,0,8'ha7,8'h00,9'h002,0,0,0,8'h33,8'h33}};
   // ==========================================================
   // Design and peripheral model
   // ==========================================================
   spd_page_decoder dut_u (.clock(clock), .rst_n(rst_n), .core_rd(core_rd), .core_wr(core_wr),
      .core_direct(core_direct), .core_bit(core_bit), .core_bit_idx(core_bit_idx), .core_addr(core_addr),
      .core_wdata(core_wdata), .per_rdata(per_rdata), .core_rdata_q(core_rdata_q), .core_rvalid_q(core_rvalid_q),
      .sfr_page_q(sfr_page_q), .per_sel_q(per_sel_q), .per_rd_q(per_rd_q), .per_wr_q(per_wr_q),
      .per_addr_q(per_addr_q), .per_wdata_q(per_wdata_q), .per_bit_q(per_bit_q), .per_bit_idx_q(per_bit_idx_q),
      .per_all_page_q(per_all_page_q), .per_target_q(per_target_q),
      .reserved_q(reserved_q), .bit_refused_q(bit_refused_q));
   spd_periph_model periph_u (.clock(clock), .rst_n(rst_n), .per_rd_q(per_rd_q), .per_addr_q(per_addr_q),
      .per_rdata(per_rdata));
   // ==========================================================
   // Clock, timeout and helpers
   // ==========================================================
   // Free running clock, 10 ns period
   always #5 clock = ~clock;
   // Cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc >= 1000) begin
         err_total++;
         complete_run();
      end
   end
   // Compare and report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One core request, then sample both answer cycles
   task automatic acc(input logic rd, wr, bt, dr, input logic [7:0] a, wd);
      @(negedge clock);
      {core_rd, core_wr, core_bit, core_direct, core_addr, core_wdata} = {rd, wr, bt, dr, a, wd};
      @(negedge clock);
      {core_rd, core_wr} = 2'b00;
      {s_sel, s_res, s_ref, s_tgt, s_pg} = {per_sel_q, reserved_q, bit_refused_q, per_target_q, sfr_page_q};
      s_rw = {per_rd_q, per_wr_q};
      @(negedge clock);
      {s_rv, s_rd} = {core_rvalid_q, core_rdata_q};
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (2) @(negedge clock);
      chk(sfr_page_q, 8'h00); // Page at reset
      chk(per_target_q, 9'h001); // Target at reset
      rst_n = 1'b1;
      // Table of ordinary accesses; the core avoids unassigned places on real pages
      foreach (rows[i]) begin
         acc(rows[i].rd, rows[i].wr, rows[i].bt, 1'b1, rows[i].a, rows[i].wd);
         if (rows[i].tgt != 9'h000) chk(s_tgt, rows[i].tgt); // Decoded target
         chk({s_sel, s_res, s_ref}, {rows[i].sel, rows[i].res, rows[i].rf}); // Strobes
         chk(s_rw, {rows[i].sel & rows[i].rd, rows[i].sel & rows[i].wr}); // Read or write qualifier
         chk(s_pg, rows[i].pg); // Page after access
         chk(s_rv, rows[i].rd); // Read answer strobe
         if (rows[i].rd) chk(s_rd, rows[i].rx); // Read byte
      end
      // Accesses outside the direct register space are ignored
      acc(1'b1, 1'b0, 1'b0, 1'b0, 8'hc4, 8'h00);
      chk({s_sel, s_rv}, 2'b00); // Indirect mode
      acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h27, 8'h0f);
      chk({s_sel, s_pg}, {1'b0, 8'h33}); // Low address, no page change
      // Page write immediately followed by a paged read
      @(negedge clock);
      {core_wr, core_addr, core_wdata} = {1'b1, 8'ha7, 8'h0f};
      @(negedge clock);
      {core_wr, core_rd, core_addr} = {1'b0, 1'b1, 8'hc4};
      @(negedge clock);
      core_rd = 1'b0;
      chk(per_target_q, 9'h020); // New page used at once
      @(negedge clock);
      chk({core_rvalid_q, core_rdata_q}, {1'b1, 8'h9e}); // Forwarded read byte
      // Reset in mid-run restores page 0
      @(negedge clock);
      rst_n = 1'b0;
      #1 chk(sfr_page_q, 8'h00); // Asynchronous clear
      @(negedge clock);
      rst_n = 1'b1;
      acc(1'b1, 1'b0, 1'b0, 1'b1, 8'hc4, 8'h00);
      chk(s_tgt, 9'h010); // Page 0 decode again
      // Bit write to an all-page register carries its payload to the peripheral
      core_bit_idx = 3'h5;
      acc(1'b0, 1'b1, 1'b1, 1'b1, 8'ha8, 8'h20);
      chk({s_sel, s_rw, s_tgt}, {1'b1, 2'b01, 9'h004}); // Forwarded bit write
      chk({per_bit_q, per_bit_idx_q, per_wdata_q, per_all_page_q}, {1'b1, 3'h5, 8'h20, 1'b1}); // Payload
      complete_run();
   end
endmodule
